// ==== dv/srsc_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module srsc_board (
  input  wire logic       core_clk,
  output var  logic       system_reset_n,
  output var  logic       pair01_merge_n,
  output var  logic       pair23_merge_n,
  output var  logic       pair45_merge_n,
  output var  logic       reset_hold_strap,
  output var  logic [3:0] switch_mode_strap
);
  initial begin
    system_reset_n = 1'b0;
    {pair45_merge_n, pair23_merge_n, pair01_merge_n} = 3'h7;
    reset_hold_strap = 1'b0;
    switch_mode_strap = 4'h0;
  end
  task hold(input logic [2:0] m, input logic h, input logic [3:0] md);
    @(posedge core_clk);
    system_reset_n <= 1'b0;
    {pair45_merge_n, pair23_merge_n, pair01_merge_n} <= ~m;
    reset_hold_strap <= h;
    switch_mode_strap <= md;
  endtask
  // mode strap never touched after release
  task release_rst();
    @(posedge core_clk);
    system_reset_n <= 1'b1;
  endtask
  task flip_merges();
    @(posedge core_clk);
    {pair45_merge_n, pair23_merge_n, pair01_merge_n} <= ~{pair45_merge_n, pair23_merge_n, pair01_merge_n};
  endtask
endmodule // srsc_board
`default_nettype wire

// ==== dv/srsc_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module srsc_chk (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        system_reset_n,
  input wire logic        reset_hold_strap,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pair01_merge_n,
  input wire logic        pair23_merge_n,
  input wire logic        pair45_merge_n,
  input wire logic        core_reset_n,
  input wire logic        link_fund_reset,
  input wire logic        smbus_enable,
  input wire logic        eeprom_init_req,
  input wire logic        mode_reserved,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0]  pair_merged,
  input wire logic [3:0]  switch_mode,
  input wire logic [3:0]  switch_mode_strap,
  input wire logic [15:0] lane_map_port0,
  input wire logic [15:0] lane_map_port2,
  input wire logic [15:0] lane_map_port4
);
  wire halted = smbus_enable && !core_reset_n;
  wire clr = psel && penable && pwrite && paddr == 12'h000 && !pwdata[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_MERGE: assert property ($rose(system_reset_n) |-> ##[1:3]
    pair_merged == ~{pair45_merge_n, pair23_merge_n, pair01_merge_n}) else $error("merge");
  AST_LANE0: assert property (lane_map_port0 == (pair_merged[0] ? 16'h5500 : 16'h0)) else $error("l0");
  AST_LANE2: assert property (lane_map_port2 == (pair_merged[1] ? 16'h5500 : 16'h0)) else $error("l2");
  AST_LANE4: assert property (lane_map_port4 == (pair_merged[2] ? 16'h5500 : 16'h0)) else $error("l4");
  AST_MODE: assert property ($rose(system_reset_n) |-> ##[1:3] switch_mode == switch_mode_strap)
    else $error("mode");
  AST_DEC: assert property (eeprom_init_req == (switch_mode == 4'h1) && mode_reserved == (switch_mode > 4'h1))
    else $error("decode");
  AST_RST: assert property (!system_reset_n [*2] |-> !core_reset_n && link_fund_reset && !smbus_enable)
    else $error("reset");
  AST_PROC: assert property ($rose(system_reset_n) && reset_hold_strap |-> ##[15:30] halted)
    else $error("halt");
  AST_STAY: assert property (halted && system_reset_n && !clr && !$past(clr) && !$past(clr, 2) |=> halted)
    else $error("stay");
  AST_EXIT: assert property (halted && clr |-> ##[1:4] core_reset_n) else $error("exit");
  AST_HOLD: assert property (core_reset_n |-> $stable(pair_merged) && $stable(switch_mode))
    else $error("hold");
  cover property (halted);
  cover property ($rose(core_reset_n));
  cover property (pair_merged == 3'h7);
endmodule // srsc_chk
bind srsc_reset_strap srsc_chk srsc_chk_inst (
  .core_clk          (core_clk),
  .rstn              (rstn),
  .system_reset_n    (system_reset_n),
  .reset_hold_strap  (reset_hold_strap),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .pair01_merge_n    (pair01_merge_n),
  .pair23_merge_n    (pair23_merge_n),
  .pair45_merge_n    (pair45_merge_n),
  .core_reset_n      (core_reset_n),
  .link_fund_reset   (link_fund_reset),
  .smbus_enable      (smbus_enable),
  .eeprom_init_req   (eeprom_init_req),
  .mode_reserved     (mode_reserved),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .pair_merged       (pair_merged),
  .switch_mode       (switch_mode),
  .switch_mode_strap (switch_mode_strap),
  .lane_map_port0    (lane_map_port0),
  .lane_map_port2    (lane_map_port2),
  .lane_map_port4    (lane_map_port4)
);
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srsc_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire         system_reset_n, pair01_merge_n, pair23_merge_n, pair45_merge_n, reset_hold_strap;
  wire         pready, pslverr, core_reset_n, link_fund_reset, smbus_enable, eeprom_init_req, mode_reserved;
  wire [3:0]   switch_mode_strap, switch_mode;
  wire [2:0]   pair_merged;
  wire [31:0]  prdata;
  wire [15:0]  lane_map_port0, lane_map_port2, lane_map_port4;
  int          bad_count = 0, comparisons = 0;
  srsc_reset_strap srsc_reset_strap_inst (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .system_reset_n    (system_reset_n),
    .pair01_merge_n    (pair01_merge_n),
    .pair23_merge_n    (pair23_merge_n),
    .pair45_merge_n    (pair45_merge_n),
    .reset_hold_strap  (reset_hold_strap),
    .switch_mode_strap (switch_mode_strap),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pready            (pready),
    .prdata            (prdata),
    .pslverr           (pslverr),
    .core_reset_n      (core_reset_n),
    .link_fund_reset   (link_fund_reset),
    .smbus_enable      (smbus_enable),
    .pair_merged       (pair_merged),
    .lane_map_port0    (lane_map_port0),
    .lane_map_port2    (lane_map_port2),
    .lane_map_port4    (lane_map_port4),
    .switch_mode       (switch_mode),
    .eeprom_init_req   (eeprom_init_req),
    .mode_reserved     (mode_reserved)
  );
  srsc_board srsc_board_inst (
    .core_clk          (core_clk),
    .system_reset_n    (system_reset_n),
    .pair01_merge_n    (pair01_merge_n),
    .pair23_merge_n    (pair23_merge_n),
    .pair45_merge_n    (pair45_merge_n),
    .reset_hold_strap  (reset_hold_strap),
    .switch_mode_strap (switch_mode_strap)
  );
  always #2.5 core_clk = ~core_clk;
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task t_cfg(input logic [2:0] m, input logic h, input logic [3:0] md);
    int k;
    srsc_board_inst.hold(m, h, md);
    repeat (3) @(negedge core_clk);
    `CHK("in reset", 2'b01, {core_reset_n, link_fund_reset})
    srsc_board_inst.release_rst();
    repeat (5) @(negedge core_clk);
    `CHK("procedure", 3'b010, {core_reset_n, link_fund_reset, smbus_enable})
    for (k = 0; k < 60 && smbus_enable !== 1'b1; k++) @(negedge core_clk);
    `CHK("state", {!h, 2'b01}, {core_reset_n, link_fund_reset, smbus_enable})
    `CHK("merged", m, pair_merged)
    `CHK("lane0", {m[0] ? 8'h55 : 8'h00, 8'h00}, lane_map_port0)
    `CHK("lane2", {m[1] ? 8'h55 : 8'h00, 8'h00}, lane_map_port2)
    `CHK("lane4", {m[2] ? 8'h55 : 8'h00, 8'h00}, lane_map_port4)
    `CHK("mode", {md, md == 4'h1, md > 4'h1}, {switch_mode, eeprom_init_req, mode_reserved})
    apb(1'b0, `SRSC_OFF_CONFIG, 32'h0);
    `CHK("config", {22'h0, md > 4'h1, md == 4'h1, md, 1'b0, m}, rd)
    if (h) begin
      apb(1'b0, `SRSC_OFF_STATUS, 32'h0);
      `CHK("halted bit", 1'b1, rd[0])
      apb(1'b1, `SRSC_OFF_CTRL, 32'h1);
      repeat (4) @(negedge core_clk);
      `CHK("halt stays", 1'b0, core_reset_n)
      apb(1'b1, `SRSC_OFF_CTRL, 32'h0);
      repeat (4) @(negedge core_clk);
      `CHK("halt exit", 1'b1, core_reset_n)
    end else begin
      apb(1'b0, `SRSC_OFF_STATUS, 32'h0);
      `CHK("run bit", 3'b010, rd[2:0])
    end
    srsc_board_inst.flip_merges();
    repeat (3) @(negedge core_clk);
    `CHK("kept", m, pair_merged)
    $display("t_cfg %h %h %h done", m, h, md);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_cfg(3'h0, 1'b0, 4'h0);
    t_cfg(3'h7, 1'b1, 4'h1);
    t_cfg(3'h5, 1'b0, 4'h2);
    t_cfg(3'h2, 1'b1, 4'hF);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("no error", 1'b0, pslverr)
    report_and_stop();
  end
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

// ==== logic/srsc_defs.vh ====
`ifndef SRSC_DEFS_VH
`define SRSC_DEFS_VH

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define SRSC_OFF_CTRL       12'h000
`define SRSC_OFF_STATUS     12'h004
`define SRSC_OFF_CONFIG     12'h008

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define SRSC_CTRL_HALT_BIT  0
`define SRSC_CTRL_RESET     32'h0000_0001
`define SRSC_ST_HALTED_BIT  0
`define SRSC_ST_RUN_BIT     1
`define SRSC_ST_INRST_BIT   2
`define SRSC_CFG_M01_BIT    0
`define SRSC_CFG_M23_BIT    1
`define SRSC_CFG_M45_BIT    2
`define SRSC_CFG_MODE_LSB   4
`define SRSC_CFG_EEP_BIT    8
`define SRSC_CFG_RSVD_BIT   9

// -----------------------------------------------------------------
// switch mode encodings
// -----------------------------------------------------------------
`define SRSC_MODE_NORMAL    4'h0
`define SRSC_MODE_EEPROM    4'h1

// -----------------------------------------------------------------
// timing: reset procedure length
// -----------------------------------------------------------------
`define SRSC_RST_PROC_NS    100
`define SRSC_CLK_NS         5
// 100 ns at a 5 ns clock, sized for the 8-bit procedure counter
`define SRSC_RST_CYCLES     8'h14

`endif

// ==== logic/srsc_reset_strap.v ====
// What this block does
// - merge23 strap low: ports 2,3 one x8
// - merge23 strap high: ports 2,3 separate x4
// - merge45 strap low: ports 4,5 one x8
// - merge45 strap high: ports 4,5 separate x4
// - merge01 strap low x8, high two x4
// - system reset clears logic, starts link reset
// - halt strap holds reset, SMBus stays alive
// - only clearing halt bit releases halted state
// - mode 0 normal, 1 eeprom, rest reserved
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "srsc_defs.vh"

module srsc_reset_strap (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        system_reset_n,
  input  wire        pair01_merge_n,
  input  wire        pair23_merge_n,
  input  wire        pair45_merge_n,
  input  wire        reset_hold_strap,
  input  wire [3:0]  switch_mode_strap,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  output reg         core_reset_n,
  output reg         link_fund_reset,
  output reg         smbus_enable,
  output reg  [2:0]  pair_merged,
  output reg  [15:0] lane_map_port0,
  output reg  [15:0] lane_map_port2,
  output reg  [15:0] lane_map_port4,
  output reg  [3:0]  switch_mode,
  output reg         eeprom_init_req,
  output reg         mode_reserved
);

  // -----------------------------------------------------------------
  // state machine
  // -----------------------------------------------------------------
  localparam [1:0] ST_RESET  = 2'b00;
  localparam [1:0] ST_PROC   = 2'b01;
  localparam [1:0] ST_HALTED = 2'b10;
  localparam [1:0] ST_RUN    = 2'b11;
  localparam [7:0] RST_CNT   = `SRSC_RST_CYCLES;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [7:0]  cnt;
  reg         sysrst_q;
  reg         halt_bit;
  reg         halt_strap_cap;
  reg  [3:0]  mode_cap;
  reg  [2:0]  merge_cap;
  reg  [31:0] next_prdata;
  wire [15:0] next_lane_map_port0;
  wire [15:0] next_lane_map_port2;
  wire [15:0] next_lane_map_port4;
  wire        bus_wr;
  wire        halt_clr;
  wire        proc_done;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  // zero-wait slave: every access ends in its first access cycle
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign bus_wr    = psel & penable & pwrite;
  // only a written 0 clears the halt bit; a written 1 is ignored
  assign halt_clr  = bus_wr && (paddr == `SRSC_OFF_CTRL) && !pwdata[`SRSC_CTRL_HALT_BIT];
  assign proc_done = (cnt == RST_CNT);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // system reset low overrides every state
  always @* begin
    next_state = state;
    case (state)
      ST_RESET:  if (system_reset_n) next_state = ST_PROC;
      ST_PROC:   if (proc_done) next_state = halt_strap_cap ? ST_HALTED : ST_RUN;
      ST_HALTED: if (!halt_bit) next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_RESET;
    endcase
    if (!system_reset_n) next_state = ST_RESET;
  end

  // -----------------------------------------------------------------
  // sequencing
  // -----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state           <= ST_RESET;
      cnt             <= 8'h00;
      sysrst_q        <= 1'b0;
      core_reset_n    <= 1'b0;
      link_fund_reset <= 1'b1;
      smbus_enable    <= 1'b0;
    end else begin
      state           <= next_state;
      sysrst_q        <= system_reset_n;
      cnt             <= (state == ST_PROC && !proc_done) ? cnt + 8'h01 : 8'h00;
      core_reset_n    <= (next_state == ST_RUN);
      link_fund_reset <= (next_state == ST_RESET) || (next_state == ST_PROC);
      smbus_enable    <= (next_state == ST_HALTED) || (next_state == ST_RUN);
    end
  end

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  // sysrst_q starts low, so the first high edge after rstn captures too
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt_strap_cap <= 1'b0;
      mode_cap       <= 4'h0;
      merge_cap      <= 3'h0;
    end else begin
      if (!system_reset_n) begin
        halt_strap_cap <= reset_hold_strap;
      end
      if (system_reset_n && !sysrst_q) begin
        mode_cap  <= switch_mode_strap;
        merge_cap <= {~pair45_merge_n, ~pair23_merge_n, ~pair01_merge_n};
      end
    end
  end

  // -----------------------------------------------------------------
  // halt bit
  // -----------------------------------------------------------------
  // strap load wins over a bus clear while system reset is low
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt_bit <= 1'b0;
    end else if (!system_reset_n) begin
      halt_bit <= reset_hold_strap;
    end else if (halt_clr) begin
      halt_bit <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // configuration outputs: lane maps, mode decode
  // -----------------------------------------------------------------
  // 2-bit entry per lane of the even port: 00 own lane, 01 taken from odd port
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_lane
      assign next_lane_map_port0[2*i+1:2*i] = (i >= 4 && merge_cap[0]) ? 2'b01 : 2'b00;
      assign next_lane_map_port2[2*i+1:2*i] = (i >= 4 && merge_cap[1]) ? 2'b01 : 2'b00;
      assign next_lane_map_port4[2*i+1:2*i] = (i >= 4 && merge_cap[2]) ? 2'b01 : 2'b00;
    end
  endgenerate

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pair_merged     <= 3'h0;
      lane_map_port0  <= 16'h0000;
      lane_map_port2  <= 16'h0000;
      lane_map_port4  <= 16'h0000;
      switch_mode     <= 4'h0;
      eeprom_init_req <= 1'b0;
      mode_reserved   <= 1'b0;
    end else begin
      pair_merged     <= merge_cap;
      lane_map_port0  <= next_lane_map_port0;
      lane_map_port2  <= next_lane_map_port2;
      lane_map_port4  <= next_lane_map_port4;
      switch_mode     <= mode_cap;
      eeprom_init_req <= (mode_cap == `SRSC_MODE_EEPROM);
      mode_reserved   <= (mode_cap != `SRSC_MODE_NORMAL) && (mode_cap != `SRSC_MODE_EEPROM);
    end
  end

  // -----------------------------------------------------------------
  // apb read data
  // -----------------------------------------------------------------
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `SRSC_OFF_CTRL: next_prdata[`SRSC_CTRL_HALT_BIT] = halt_bit;
      `SRSC_OFF_STATUS: begin
        next_prdata[`SRSC_ST_HALTED_BIT] = (state == ST_HALTED);
        next_prdata[`SRSC_ST_RUN_BIT]    = (state == ST_RUN);
        next_prdata[`SRSC_ST_INRST_BIT]  = (state == ST_RESET) || (state == ST_PROC);
      end
      `SRSC_OFF_CONFIG: begin
        next_prdata[`SRSC_CFG_M45_BIT:`SRSC_CFG_M01_BIT]     = merge_cap;
        next_prdata[`SRSC_CFG_MODE_LSB+3:`SRSC_CFG_MODE_LSB] = mode_cap;
        next_prdata[`SRSC_CFG_EEP_BIT]                       = eeprom_init_req;
        next_prdata[`SRSC_CFG_RSVD_BIT]                      = mode_reserved;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // -----------------------------------------------------------------
  // read data register
  // -----------------------------------------------------------------
  // loaded in the setup cycle, so the zero-wait access sees a flop
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule // srsc_reset_strap

`default_nettype wire
